// >>> core/uart_rx_pkg.sv
/*
  Shared constants, types and decoders for the serial receive and break path
  and for the remote transmitter end that drives it.
  Assumes one 10 MHz system clock and a synchronous active-low reset.
*/
package uart_rx_pkg;
  // Oversampling and vote positions inside one bit time
  localparam int          OVERSAMPLE    = 16;
  localparam logic [3:0]  SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0]  SAMPLE_LAST   = 4'h9;
  localparam logic [3:0]  PHASE_LAST    = 4'hF;
  // Receive buffer depth and break length in zero bits
  localparam int          FIFO_DEPTH    = 4;
  localparam logic [3:0]  BREAK_ZEROS   = 4'hD;
  localparam logic [7:0]  BREAK_TICKS   = 8'hD0;
  localparam logic [7:0]  HOST_BREAK_BITS = 8'h14;
  // Remote end register map, byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_TXDATA    = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // Field positions
  localparam int          CTRL_ENABLE   = 0;
  localparam int          CTRL_NINE     = 1;
  localparam int          CTRL_PAR_ON   = 2;
  localparam int          CTRL_PAR_LSB  = 3;
  localparam int          CTRL_BAD_STOP = 5;
  localparam int          CTRL_DIV_LSB  = 16;
  localparam int          TXD_BREAK     = 9;
  localparam int          STS_BUSY      = 0;
  localparam int          STS_LINE      = 1;
  localparam int          STS_BREAK     = 2;

  typedef enum logic [1:0] {
    PAR_EVEN  = 2'b00,
    PAR_ODD   = 2'b01,
    PAR_MARK  = 2'b10,
    PAR_SPACE = 2'b11
  } parity_t;

  typedef enum logic [2:0] {
    RX_IDLE      = 3'b000,
    RX_START     = 3'b001,
    RX_DATA      = 3'b010,
    RX_STOP      = 3'b011,
    RX_WAIT_HIGH = 3'b100
  } rx_state_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_ZERO = 2'b01,
    BK_STOP = 2'b10
  } break_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SEND  = 2'b01,
    H_BREAK = 2'b10
  } host_state_t;

  // Parity bit expected for the given xor of the data bits
  function automatic logic parity_expect(input logic dataXor, input parity_t sel);
    case (sel)
      PAR_EVEN: parity_expect = dataXor;
      PAR_ODD:  parity_expect = ~dataXor;
      PAR_MARK: parity_expect = 1'b1;
      default:  parity_expect = 1'b0;
    endcase
  endfunction : parity_expect
endpackage : uart_rx_pkg

// >>> core/uart_link_if.sv
/*
  Serial line pair between the receiving device and the remote transmitter.
  Assumes both ends share clk_sys; the lines are plain push-pull levels.
*/
`timescale 1ns/1ns
interface uart_link_if;
  logic rxLine;   // Remote to device serial data, idle high
  logic txLine;   // Device to remote, carries break characters

  modport device (input rxLine, output txLine);
  modport remote (output rxLine, input txLine);
endinterface : uart_link_if

// >>> core/baud_tick.sv
/*
  Divider giving a one-cycle enable at sixteen times the baud rate.
  Assumes a divisor held stable while run is high.
*/
`timescale 1ns/1ns
module baud_tick #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] count;

  // One tick every divisor+1 clocks; restarts from zero when stopped
  always_ff @(posedge clk_sys) begin
    if (!rstn || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= divisor) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : baud_tick

// >>> core/uart_rx_device.sv
/*
  Receive path and break generator of the serial port: 16x data recovery,
  four-word receive buffer, error flags, idle status and interrupt request.
  Assumes the CPU side gives one-cycle status and data read strobes and
  holds format and baud settings stable while the port is on.
*/
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module uart_rx_device #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  uart_link_if.device           link,
  input  wire logic             serialPortOn,
  input  wire logic             rxOn,
  input  wire logic             nineBitSelect,
  input  wire logic             parityOn,
  input  wire logic [1:0]       parityTypeSel,
  input  wire logic             stopTwo,
  input  wire logic             breakRequest,
  input  wire logic             rxIrqOn,
  input  wire logic [2:0]       triggerLevel,
  input  wire logic [DIV_W-1:0] baudDivisor,
  input  wire logic             statusRead,
  input  wire logic             dataRead,
  output logic [7:0]            rxData,
  output logic                  rxNinthBit,
  output logic                  rxAvailFlag,
  output logic                  overrunFlag,
  output logic                  noiseFlag,
  output logic                  frameErrorFlag,
  output logic                  parityErrorFlag,
  output logic                  rxIdleFlag,
  output logic                  txIdleFlag,
  output logic                  txEmptyFlag,
  output logic [2:0]            rxWordCount,
  output logic                  rxIrq
);
  localparam int PTR_W = $clog2(uart_rx_pkg::FIFO_DEPTH);

  logic                   tick;
  uart_rx_pkg::rx_state_t rxState;
  logic [3:0]             rxPhase;
  logic [3:0]             bitIdx;
  logic                   sampleA;
  logic                   sampleB;
  logic                   vote;
  logic                   noisy;
  logic                   noiseSeen;
  logic [8:0]             rxShiftReg;
  logic                   wordDone;
  logic [8:0]             doneWord;
  logic                   doneFrameErr;
  logic                   doneParErr;
  logic                   doneNoise;
  logic [8:0]             fifoMem [uart_rx_pkg::FIFO_DEPTH];
  logic [PTR_W-1:0]       wrPtr;
  logic [PTR_W-1:0]       rdPtr;
  logic                   pop;
  logic                   room;
  logic                   push;
  logic [2:0]             next_count;
  logic [2:0]             trigEff;
  logic                   statusSeen;
  logic                   clearSeq;
  logic [8:0]             word;
  logic                   dataXor;
  logic                   parBit;
  uart_rx_pkg::break_state_t bkState;
  logic [DIV_W:0]         breakHeld;
  logic [3:0]             txPhase;
  logic [3:0]             zeroCnt;
  logic                   stopCnt;
  logic                   bitEnd;

  // one 16x tick source shared by receive and break timing
  baud_tick #(.DIV_W(DIV_W)) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (serialPortOn),
    .divisor (baudDivisor),
    .tick    (tick)
  );

  // majority of the three samples around mid-bit; disagreement is noise
  assign vote  = (sampleA & sampleB) | (sampleA & link.rxLine) | (sampleB & link.rxLine);
  assign noisy = !((sampleA == sampleB) && (sampleB == link.rxLine));
  wire decide = tick && (rxPhase == uart_rx_pkg::SAMPLE_LAST);

  // assembled word; for eight-bit frames the shifter holds it one place high
  assign word    = nineBitSelect ? rxShiftReg : {1'b0, rxShiftReg[8:1]};
  assign dataXor = nineBitSelect ? ^word[7:0] : ^word[6:0];
  assign parBit  = nineBitSelect ? word[8] : word[7];

  // Receive sequencer: start hunt, data bits, stop bit, wait for high line
  always_ff @(posedge clk_sys) begin
    wordDone <= 1'b0;
    if (!rstn || !serialPortOn) begin
      rxState    <= uart_rx_pkg::RX_IDLE;
      rxPhase    <= 4'h0;
      bitIdx     <= 4'h0;
      sampleA    <= 1'b1;
      sampleB    <= 1'b1;
      noiseSeen  <= 1'b0;
      rxShiftReg <= 9'h000;
      rxIdleFlag <= 1'b1;
      doneWord   <= 9'h000;
      doneFrameErr <= 1'b0;
      doneParErr <= 1'b0;
      doneNoise  <= 1'b0;
    end else begin
      if (tick) begin
        rxPhase <= rxPhase + 4'h1;
        if (rxPhase == uart_rx_pkg::SAMPLE_FIRST) sampleA <= link.rxLine;
        if (rxPhase == uart_rx_pkg::SAMPLE_FIRST + 4'h1) sampleB <= link.rxLine;
      end
      case (rxState)
        uart_rx_pkg::RX_IDLE: begin
          // hunt only once the receiver is switched on
          if (rxOn && !link.rxLine) begin
            rxState    <= uart_rx_pkg::RX_START;
            rxPhase    <= 4'h0;
            noiseSeen  <= 1'b0;
            rxIdleFlag <= 1'b0;
          end
        end
        uart_rx_pkg::RX_START: begin
          if (decide) begin
            noiseSeen <= noisy;
            bitIdx    <= 4'h0;
            // A start bit that votes high was a glitch: back to hunting
            rxState    <= vote ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
            rxIdleFlag <= vote;
          end
        end
        uart_rx_pkg::RX_DATA: begin
          if (decide) begin
            // least significant bit first, shifted in from the top
            rxShiftReg <= {vote, rxShiftReg[8:1]};
            noiseSeen  <= noiseSeen | noisy;
            bitIdx     <= bitIdx + 4'h1;
            if (bitIdx == (nineBitSelect ? 4'h8 : 4'h7)) rxState <= uart_rx_pkg::RX_STOP;
          end
        end
        uart_rx_pkg::RX_STOP: begin
          if (decide) begin
            // stop bit sampled, hand the word to the buffer
            wordDone <= 1'b1;
            // a break arrives as all zeros with a bad stop
            doneWord <= word;
            // low at the stop position is a framing error
            doneFrameErr <= !vote;
            doneParErr <= parityOn && (parBit != uart_rx_pkg::parity_expect(dataXor,
                                                   uart_rx_pkg::parity_t'(parityTypeSel)));
            doneNoise  <= noiseSeen | noisy;
            rxIdleFlag <= 1'b1;
            // bad stop level means wait for the line to return high
            rxState <= vote ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_WAIT_HIGH;
          end
        end
        uart_rx_pkg::RX_WAIT_HIGH: begin
          if (link.rxLine) rxState <= uart_rx_pkg::RX_IDLE;
        end
        default: rxState <= uart_rx_pkg::RX_IDLE;
      endcase
    end
  end

  // a word is taken while a slot is free or one leaves in the same cycle
  assign pop  = dataRead && (rxWordCount != 3'h0);
  assign room = (rxWordCount < 3'(uart_rx_pkg::FIFO_DEPTH)) || pop;
  assign push = wordDone && room;
  assign next_count = rxWordCount + {2'b00, push} - {2'b00, pop};
  assign trigEff    = (triggerLevel == 3'h0) ? 3'h1 : triggerLevel;

  // Buffer storage; contents are never overwritten on overrun
  always_ff @(posedge clk_sys) begin
    if (push) fifoMem[wrPtr] <= doneWord;
  end

  // disable empties the buffer and clears the count
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn) begin
      wrPtr       <= '0;
      rdPtr       <= '0;
      rxWordCount <= 3'h0;
      rxData      <= 8'h00;
      rxNinthBit  <= 1'b0;
      rxAvailFlag <= 1'b0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      // oldest word out on each data read while not empty; count minus one unless a word lands in the same cycle
      if (pop) begin
        rdPtr      <= rdPtr + 1'b1;
        rxData     <= fifoMem[rdPtr][7:0];
        rxNinthBit <= fifoMem[rdPtr][8];
      end
      // count and data-available track the buffer fill
      rxWordCount <= next_count;
      rxAvailFlag <= next_count != 3'h0;
    end
  end

  // a status read arms the clear, the following data read fires it
  assign clearSeq = dataRead && statusSeen;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn) statusSeen <= 1'b0;
    else if (statusRead) statusSeen <= 1'b1;
    else if (dataRead) statusSeen <= 1'b0;
  end

  // Error flags; a setting event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn) begin
      overrunFlag     <= 1'b0;
      noiseFlag       <= 1'b0;
      frameErrorFlag  <= 1'b0;
      parityErrorFlag <= 1'b0;
    end else begin
      // fifth word dropped, flag raised, buffer untouched
      if (wordDone && !room) overrunFlag <= 1'b1;
      else if (clearSeq) overrunFlag <= 1'b0;
      if (push && doneNoise) noiseFlag <= 1'b1;
      else if (clearSeq) noiseFlag <= 1'b0;
      if (push && doneFrameErr) frameErrorFlag <= 1'b1;
      else if (clearSeq) frameErrorFlag <= 1'b0;
      if (push && doneParErr) parityErrorFlag <= 1'b1;
      else if (clearSeq) parityErrorFlag <= 1'b0;
    end
  end

  // request while the fill reaches the trigger level or on overrun
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn) rxIrq <= 1'b0;
    else rxIrq <= rxIrqOn && ((next_count >= trigEff) || (wordDone && !room) || overrunFlag);
  end

  assign bitEnd = tick && (txPhase == uart_rx_pkg::PHASE_LAST);

  // measure how long the break request has been held while idle
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn || !breakRequest || !txIdleFlag) breakHeld <= '0;
    else if (breakHeld <= {1'b0, baudDivisor} + 1'b1) breakHeld <= breakHeld + 1'b1;
  end

  // Break transmitter; the transmit-empty flag is never cleared here
  always_ff @(posedge clk_sys) begin
    if (!rstn || !serialPortOn) begin
      bkState     <= uart_rx_pkg::BK_IDLE;
      link.txLine <= 1'b1;
      txIdleFlag  <= 1'b1;
      // break traffic leaves the empty condition alone
      txEmptyFlag <= 1'b1;
      txPhase     <= 4'h0;
      zeroCnt     <= 4'h0;
      stopCnt     <= 1'b0;
    end else begin
      if (tick) txPhase <= txPhase + 4'h1;
      case (bkState)
        uart_rx_pkg::BK_IDLE: begin
          if (breakHeld > {1'b0, baudDivisor} + 1'b1) begin
            bkState     <= uart_rx_pkg::BK_ZERO;
            link.txLine <= 1'b0;
            txIdleFlag  <= 1'b0;
            txPhase     <= 4'h0;
            zeroCnt     <= 4'h0;
          end
        end
        uart_rx_pkg::BK_ZERO: begin
          if (bitEnd) begin
            zeroCnt <= zeroCnt + 4'h1;
            // start bit then thirteen more low bit times for the first character, thirteen low bit times for each added one
            if (zeroCnt == uart_rx_pkg::BREAK_ZEROS) begin
              // keep adding break characters while still requested
              if (breakRequest) begin
                zeroCnt <= 4'h1;
              end else begin
                bkState     <= uart_rx_pkg::BK_STOP;
                link.txLine <= 1'b1;
                stopCnt     <= 1'b0;
              end
            end
          end
        end
        uart_rx_pkg::BK_STOP: begin
          // one or two high stop bits close the last break
          if (bitEnd) begin
            if (stopTwo && !stopCnt) begin
              stopCnt <= 1'b1;
            end else begin
              bkState    <= uart_rx_pkg::BK_IDLE;
              txIdleFlag <= 1'b1;
            end
          end
        end
        default: bkState <= uart_rx_pkg::BK_IDLE;
      endcase
    end
  end
endmodule : uart_rx_device

// >>> core/uart_remote_tx.sv
/*
  Remote serial transmitter end, steered by software over classic Wishbone.
  Sends frames or long low breaks on rxLine and watches txLine for breaks.
  Assumes a single-cycle classic master that holds its request until ack.
*/
`timescale 1ns/1ns
module uart_remote_tx (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  uart_link_if.remote      link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  logic [31:0]              ctrl;
  uart_rx_pkg::host_state_t hState;
  logic                     tick;
  logic [3:0]               phase;
  logic [11:0]              frame;
  logic [7:0]               bitsLeft;
  logic                     breakSeen;
  logic [7:0]               lowRun;
  logic                     access;
  logic                     wrData;
  logic [8:0]               w;
  logic                     nine;
  uart_rx_pkg::parity_t     pSel;

  assign access = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wrData = access && wb_we_i && (wb_adr_i == uart_rx_pkg::REG_TXDATA) && wb_sel_i[0];
  assign nine   = ctrl[uart_rx_pkg::CTRL_NINE];
  assign pSel   = uart_rx_pkg::parity_t'(ctrl[uart_rx_pkg::CTRL_PAR_LSB +: 2]);

  baud_tick #(.DIV_W(16)) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (ctrl[uart_rx_pkg::CTRL_ENABLE]),
    .divisor (ctrl[uart_rx_pkg::CTRL_DIV_LSB +: 16]),
    .tick    (tick)
  );

  // Word to send, top bit replaced by parity when parity is on
  always_comb begin
    w = wb_dat_i[8:0];
    if (ctrl[uart_rx_pkg::CTRL_PAR_ON]) begin
      if (nine) w[8] = uart_rx_pkg::parity_expect(^wb_dat_i[7:0], pSel);
      else w[7] = uart_rx_pkg::parity_expect(^wb_dat_i[6:0], pSel);
    end
  end

  // Ack one cycle after the request; writes land on the acked edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= uart_rx_pkg::CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          uart_rx_pkg::REG_CTRL:   wb_dat_o <= ctrl;
          uart_rx_pkg::REG_STATUS: wb_dat_o <= {29'h0, breakSeen, link.txLine, hState != uart_rx_pkg::H_IDLE};
          default:                 wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (access && wb_we_i && (wb_adr_i == uart_rx_pkg::REG_CTRL)) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) ctrl[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // Frame and break sender; a data write while busy is ignored
  always_ff @(posedge clk_sys) begin
    if (!rstn || !ctrl[uart_rx_pkg::CTRL_ENABLE]) begin
      hState      <= uart_rx_pkg::H_IDLE;
      link.rxLine <= 1'b1;
      frame       <= 12'hFFF;
      bitsLeft    <= 8'h00;
      phase       <= 4'h0;
    end else begin
      if (tick) phase <= phase + 4'h1;
      case (hState)
        uart_rx_pkg::H_IDLE: begin
          if (wrData) begin
            phase       <= 4'h0;
            link.rxLine <= 1'b0;
            if (wb_dat_i[uart_rx_pkg::TXD_BREAK]) begin
              hState   <= uart_rx_pkg::H_BREAK;
              bitsLeft <= uart_rx_pkg::HOST_BREAK_BITS;
            end else begin
              hState   <= uart_rx_pkg::H_SEND;
              frame    <= nine ? {1'b1, !ctrl[uart_rx_pkg::CTRL_BAD_STOP], w, 1'b0}
                               : {2'b11, !ctrl[uart_rx_pkg::CTRL_BAD_STOP], w[7:0], 1'b0};
              bitsLeft <= nine ? 8'h0B : 8'h0A;
            end
          end
        end
        uart_rx_pkg::H_SEND: begin
          if (tick && phase == uart_rx_pkg::PHASE_LAST) begin
            frame       <= {1'b1, frame[11:1]};
            link.rxLine <= (bitsLeft == 8'h01) ? 1'b1 : frame[1];
            bitsLeft    <= bitsLeft - 8'h01;
            if (bitsLeft == 8'h01) hState <= uart_rx_pkg::H_IDLE;
          end
        end
        uart_rx_pkg::H_BREAK: begin
          if (tick && phase == uart_rx_pkg::PHASE_LAST) begin
            bitsLeft <= bitsLeft - 8'h01;
            if (bitsLeft == 8'h01) begin
              link.rxLine <= 1'b1;
              hState      <= uart_rx_pkg::H_IDLE;
            end
          end
        end
        default: hState <= uart_rx_pkg::H_IDLE;
      endcase
    end
  end

  // Break watch on the device line; a new break beats a status-read clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lowRun    <= 8'h00;
      breakSeen <= 1'b0;
    end else begin
      if (link.txLine) lowRun <= 8'h00;
      else if (tick && lowRun != 8'hFF) lowRun <= lowRun + 8'h01;
      if (lowRun >= uart_rx_pkg::BREAK_TICKS) breakSeen <= 1'b1;
      else if (access && !wb_we_i && wb_adr_i == uart_rx_pkg::REG_STATUS) breakSeen <= 1'b0;
    end
  end
endmodule : uart_remote_tx

// >>> testbench/uart_rx_sva.sv
/*
  Checker for the link pair and the receiving device's flags.
  Assumes divisor 1 in the bench, so one bit time is 32 clocks.
*/
`timescale 1ns/1ns
module uart_rx_sva #(
  parameter int BRK_LOW = 448
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       rxLine,
  input wire logic       txLine,
  input wire logic       serialPortOn,
  input wire logic       rxOn,
  input wire logic       breakRequest,
  input wire logic       rxIrqOn,
  input wire logic [2:0] triggerLevel,
  input wire logic       rxIdleFlag,
  input wire logic       rxAvailFlag,
  input wire logic [2:0] rxWordCount,
  input wire logic       txEmptyFlag,
  input wire logic       rxIrq
);
  int lowCnt;
  // Low run length on txLine; a short break would be missed far end
  always_ff @(posedge clk_sys) lowCnt <= (!rstn || txLine) ? 0 : lowCnt + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_idle_on_start: assert property (serialPortOn && rxOn && rxIdleFlag && $fell(rxLine) |=> !rxIdleFlag)
    else $error("idle flag high after start bit");
  a_disable_clears: assert property (!serialPortOn |=> rxWordCount == 3'h0 && rxIdleFlag && !rxAvailFlag)
    else $error("disable left buffer state");
  a_avail_count: assert property (rxAvailFlag == (rxWordCount != 3'h0))
    else $error("avail flag disagrees with count");
  a_tx_empty: assert property (txEmptyFlag)
    else $error("transmit empty dropped");
  a_break_hold: assert property ($rose(breakRequest) |=> txLine [*2])
    else $error("break started too early");
  a_break_len: assert property ($rose(txLine) |-> lowCnt >= BRK_LOW)
    else $error("break too short");
  a_irq_level: assert property (rxIrqOn && triggerLevel != 3'h0 && rxWordCount >= triggerLevel |-> ##[0:1] rxIrq)
    else $error("no irq at trigger level");
  a_irq_mask: assert property (!rxIrqOn |=> !rxIrq)
    else $error("irq while disabled");
  cover property (rxWordCount == 3'h4);
  cover property ($rose(txLine));
  cover property ($fell(rxIdleFlag));
endmodule : uart_rx_sva

// >>> testbench/tb.sv
/*
  Bench: the remote end, steered over Wishbone, sends frames to the device;
  pulses read the device. Assumes the designer's remote register map.
*/
`timescale 1ns/1ns
module tb;
  logic        clk_sys, rstn, serialPortOn, rxOn, nineBitSelect, parityOn, stopTwo, breakRequest, rxIrqOn;
  logic        statusRead, dataRead, rxNinthBit, rxAvailFlag, overrunFlag, noiseFlag, frameErrorFlag;
  logic        parityErrorFlag, rxIdleFlag, txIdleFlag, txEmptyFlag, rxIrq, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [1:0]  parityTypeSel;
  logic [2:0]  triggerLevel, rxWordCount;
  logic [3:0]  wb_sel_i;
  logic [7:0]  rxData, wb_adr_i;
  logic [15:0] baudDivisor;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  int          n_mismatch, n_checks;
  uart_link_if link();
  uart_rx_device uart_rx_device_i(.*);
  uart_remote_tx uart_remote_tx_i(.*);
  uart_rx_sva uart_rx_sva_i(.*, .rxLine(link.rxLine), .txLine(link.txLine));
  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task end_sim;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // A wait that ran out ends the run as a failure
  task bound(input logic ok);
    if (!ok) begin
      n_mismatch++;
      end_sim();
    end
  endtask : bound
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    bound(wb_ack_o === 1'b1);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  // Write a word, poll busy, then let the device land the word
  task send(input logic [31:0] d);
    int k;
    wb(1'b1, 8'h04, d);
    k = 0;
    do begin
      wb(1'b0, 8'h08, 32'h0);
      k++;
    end while (rdat[0] !== 1'b0 && k < 400);
    bound(rdat[0] === 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask : send
  // One-cycle status (s=1) or data (s=0) read strobe
  task pulse(input logic s);
    @(posedge clk_sys);
    {statusRead, dataRead} <= {s, ~s};
    @(posedge clk_sys);
    {statusRead, dataRead} <= 2'b00;
    @(posedge clk_sys);
  endtask : pulse
  // Remote control word and device format inputs; device parity enable comes from q, not p
  task cfg(input logic n, p, q, input logic [1:0] t, input logic b);
    wb(1'b1, 8'h00, {16'h0001, 10'h000, b, t, p, n, 1'b1});
    {nineBitSelect, parityOn, parityTypeSel} <= {n, q, t};
  endtask : cfg
  // Main sequence
  initial begin
    {rstn, statusRead, dataRead, breakRequest, nineBitSelect, parityOn, parityTypeSel, stopTwo} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {serialPortOn, rxOn, rxIrqOn, triggerLevel, baudDivisor, wb_sel_i} = {3'b111, 3'h4, 16'h0001, 4'hF};
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
    // Five unread words: the fifth is lost
    for (int i = 1; i <= 5; i++) send(i * 32'h21);
    chk("count", 32'h4, rxWordCount);
    chk("overrun", 32'h1, overrunFlag);
    chk("irq", 32'h1, rxIrq);
    rxIrqOn <= 1'b0;
    pulse(1'b1);
    for (int i = 1; i <= 4; i++) begin
      pulse(1'b0);
      chk("data", i * 32'h21, rxData);
      chk("count", 32'h4 - i, rxWordCount);
    end
    chk("overrun", 32'h0, overrunFlag);
    rxIrqOn <= 1'b1;
    // Every parity type with a matching sender
    for (int t = 0; t < 4; t++) begin
      cfg(1'b0, 1'b1, 1'b1, t[1:0], 1'b0);
      send(32'h3);
      chk("parity", 32'h0, parityErrorFlag);
      pulse(1'b0);
    end
    cfg(1'b0, 1'b0, 1'b1, 2'b00, 1'b0);
    send(32'h1);
    chk("parity", 32'h1, parityErrorFlag);
    pulse(1'b1);
    pulse(1'b0);
    chk("parity", 32'h0, parityErrorFlag);
    cfg(1'b1, 1'b0, 1'b0, 2'b00, 1'b0);
    send(32'h155);
    pulse(1'b0);
    chk("word9", 32'h155, {rxNinthBit, rxData});
    // Low stop bit, then a received break
    cfg(1'b0, 1'b0, 1'b0, 2'b00, 1'b1);
    send(32'h5A);
    chk("frame", 32'h1, frameErrorFlag);
    pulse(1'b1);
    pulse(1'b0);
    chk("data", 32'h5A, rxData);
    cfg(1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
    send(32'h200);
    chk("frame", 32'h1, frameErrorFlag);
    pulse(1'b0);
    chk("data", 32'h0, rxData);
    chk("count", 32'h0, rxWordCount);
    // Held break request seen far end; two stop bits keep idle low past one bit
    {breakRequest, stopTwo} <= 2'b11;
    repeat (600) @(posedge clk_sys);
    chk("txidle", 32'h0, txIdleFlag);
    breakRequest <= 1'b0;
    repeat (316) @(posedge clk_sys);
    chk("txidle", 32'h0, txIdleFlag);
    repeat (584) @(posedge clk_sys);
    chk("txidle", 32'h1, txIdleFlag);
    wb(1'b0, 8'h08, 32'h0);
    chk("break", 32'h1, rdat[2]);
    // Receiver off: a whole frame passes unseen
    rxOn <= 1'b0;
    send(32'h22);
    chk("count", 32'h0, rxWordCount);
    rxOn <= 1'b1;
    send(32'h11);
    chk("count", 32'h1, rxWordCount);
    chk("noise", 32'h0, noiseFlag);
    serialPortOn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("count", 32'h0, rxWordCount);
    chk("frame", 32'h0, frameErrorFlag);
    end_sim();
  end
endmodule : tb
